// ---- verilog/emm_defines.svh ----
`ifndef EMM_DEFINES_SVH
`define EMM_DEFINES_SVH

// ----------------------------------------
// Register offsets (word addresses)
// ----------------------------------------
`define EMM_OFS_CTRL 4'h0
`define EMM_OFS_STATUS 4'h1
`define EMM_OFS_SEL 4'h2
`define EMM_OFS_ENTRY 4'h3
`define EMM_OFS_LOADA 4'h4
`define EMM_OFS_LOADD 4'h5

// ----------------------------------------
// Control fields
// ----------------------------------------
`define EMM_CTRL_BRK_ROM 0
`define EMM_CTRL_NRT 1
`define EMM_CTRL_DEF_LO 2
`define EMM_CTRL_DEF_HI 3
`define EMM_CTRL_RST 32'h0000_0008

// ----------------------------------------
// Status fields (write one to clear)
// ----------------------------------------
`define EMM_ST_ROMWR 0
`define EMM_ST_GUARD 1

// ----------------------------------------
// Entry word fields
// ----------------------------------------
`define EMM_ENT_VALID 31
`define EMM_ENT_EMUL 30
`define EMM_ENT_ATTR_HI 29
`define EMM_ENT_ATTR_LO 28

`endif

// ---- verilog/emm_pkg.sv ----
package emm_pkg;

    // ----------------------------------------
    // Memory kinds
    // ----------------------------------------
    typedef enum logic [1:0] {
        EMM_RAM = 2'h0,
        EMM_ROM = 2'h1,
        EMM_GUARD = 2'h2
    } emm_attr_t;

    // ----------------------------------------
    // Location of the backing memory
    // ----------------------------------------
    typedef enum logic {
        EMM_TARGET = 1'b0,
        EMM_EMUL = 1'b1
    } emm_loc_t;

endpackage : emm_pkg

// ---- verilog/emm_ram.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Emulation RAM with registered read data
// ----------------------------------------
module emm_ram #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Registered read; a same-address write shows the old word first
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : emm_ram

`default_nettype wire

// ---- verilog/emm_mapper.sv ----
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "emm_defines.svh"

// Function
// - Emulation ROM translates, signals read, blocks writes
// - Target blocks pass untranslated, show target code
// - Target attribute enables target address buffers
// - Emulation RAM translates, allows reads and writes
// - Any emulation page may back any block
// - One attribute per whole block
// - Page size is one global setting
// - Allocation is whole pages only
// - Attribute encodes RAM, ROM, guarded
// - Processor ROM write flags illegal, warns
// - Control-board loads may write ROM space
// - Guarded access flags illegal, warns
// - Guarded blocks consume no emulation pages
// - Optional break on processor ROM write
// - ROM write never changes emulation contents
// - Unmapped addresses take default, guarded at reset
// - Non-real-time monitor breaks on guarded access
module emm_mapper #(
    parameter int AW = 16,
    parameter int DW = 8,
    parameter int PGW = 8,
    parameter int NENT = 8,
    parameter int EPW = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cpu_req,
    input wire logic cpu_wr,
    input wire logic [AW-1:0] cpu_addr,
    input wire logic [DW-1:0] cpu_wdata,
    output logic [DW-1:0] cpu_rdata,
    output logic [AW-1:0] tgt_addr,
    output logic tgt_buf_en,
    output logic emu_buf_en,
    output logic [1:0] rc_attr,
    output logic rc_wr_ok,
    output logic illegal,
    output logic brk_req
);

    localparam int BW = AW - PGW;
    localparam int IW = $clog2(NENT);
    localparam int RW = EPW + PGW;

    // ----------------------------------------
    // Map entries and control registers
    // ----------------------------------------
    logic [NENT-1:0] ent_valid_r, ent_valid_nxt;
    logic [NENT-1:0] ent_emul_r, ent_emul_nxt;
    logic [1:0] ent_attr_r [NENT], ent_attr_nxt [NENT];
    logic [BW-1:0] ent_lo_r [NENT], ent_lo_nxt [NENT];
    logic [BW-1:0] ent_hi_r [NENT], ent_hi_nxt [NENT];
    logic [EPW-1:0] ent_pg_r [NENT], ent_pg_nxt [NENT];
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [IW-1:0] sel_r, sel_nxt;
    logic [RW-1:0] lda_r, lda_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // ----------------------------------------
    // Lookup
    // ----------------------------------------
    // Entry word packs valid, location, attribute, base page, bounds
    function automatic logic [31:0] ent_word(input int i);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`EMM_ENT_VALID] = ent_valid_r[i];
        w[`EMM_ENT_EMUL] = ent_emul_r[i];
        w[`EMM_ENT_ATTR_HI:`EMM_ENT_ATTR_LO] = ent_attr_r[i];
        w[24 +: EPW] = ent_pg_r[i];
        w[12 +: BW] = ent_hi_r[i];
        w[0 +: BW] = ent_lo_r[i];
        return w;
    endfunction : ent_word

    logic [BW-1:0] blk;
    logic hit;
    logic [IW-1:0] hit_i;
    logic [1:0] attr;
    logic emul;
    logic [RW-1:0] ram_a;

    // First matching entry wins; whole block shares one attribute
    always_comb begin
        blk = cpu_addr[AW-1:PGW];
        hit = 1'b0;
        hit_i = '0;
        for (int i = NENT - 1; i >= 0; i--) begin
            if (ent_valid_r[i] && blk >= ent_lo_r[i] && blk <= ent_hi_r[i]) begin
                hit = 1'b1;
                hit_i = IW'(i);
            end
        end
        if (hit) begin
            attr = ent_attr_r[hit_i];
            emul = ent_emul_r[hit_i] && (ent_attr_r[hit_i] != 2'(emm_pkg::EMM_GUARD));
        end else begin
            attr = ctrl_r[`EMM_CTRL_DEF_HI:`EMM_CTRL_DEF_LO];
            emul = 1'b0;
        end
        // Block offset plus base page; page offset unchanged
        ram_a = {EPW'(ent_pg_r[hit_i] + EPW'(blk - ent_lo_r[hit_i])),
                 cpu_addr[PGW-1:0]};
    end

    logic is_rom, is_guard, is_ram, ram_we, bad_rom, bad_grd;

    // Access decode
    always_comb begin
        is_rom = attr == 2'(emm_pkg::EMM_ROM);
        is_guard = (attr != 2'(emm_pkg::EMM_RAM)) && !is_rom;
        is_ram = attr == 2'(emm_pkg::EMM_RAM);
        bad_rom = cpu_req && cpu_wr && is_rom;
        bad_grd = cpu_req && is_guard;
        ram_we = cpu_req && cpu_wr && emul && is_ram;
    end

    // ----------------------------------------
    // Emulation RAM, shared with control loads
    // ----------------------------------------
    logic load_we, mem_we;
    logic [RW-1:0] mem_a;
    logic [DW-1:0] mem_d, mem_q;

    // Control board loads bypass ROM protection
    always_comb begin
        load_we = reg_wr && reg_addr == `EMM_OFS_LOADD;
        mem_we = load_we || ram_we;
        mem_a = load_we ? lda_r : ram_a;
        mem_d = load_we ? reg_wdata[DW-1:0] : cpu_wdata;
    end

    emm_ram #(.AW(RW), .DW(DW)) u_ram (
        .mclk(mclk),
        .we(mem_we),
        .addr(mem_a),
        .wdata(mem_d),
        .rdata(mem_q)
    );

    // ----------------------------------------
    // Register next state
    // ----------------------------------------
    always_comb begin
        ent_valid_nxt = ent_valid_r;
        ent_emul_nxt = ent_emul_r;
        ent_attr_nxt = ent_attr_r;
        ent_lo_nxt = ent_lo_r;
        ent_hi_nxt = ent_hi_r;
        ent_pg_nxt = ent_pg_r;
        ctrl_nxt = ctrl_r;
        sel_nxt = sel_r;
        lda_nxt = lda_r;
        stat_nxt = stat_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                `EMM_OFS_CTRL: ctrl_nxt = reg_wdata & 32'h0000_000F;
                `EMM_OFS_STATUS: stat_nxt = stat_r & ~reg_wdata[1:0];
                `EMM_OFS_SEL: sel_nxt = reg_wdata[IW-1:0];
                `EMM_OFS_ENTRY: begin
                    ent_valid_nxt[sel_r] = reg_wdata[`EMM_ENT_VALID];
                    ent_emul_nxt[sel_r] = reg_wdata[`EMM_ENT_EMUL];
                    ent_attr_nxt[sel_r] = reg_wdata[`EMM_ENT_ATTR_HI:`EMM_ENT_ATTR_LO];
                    ent_pg_nxt[sel_r] = reg_wdata[24 +: EPW];
                    ent_hi_nxt[sel_r] = reg_wdata[12 +: BW];
                    ent_lo_nxt[sel_r] = reg_wdata[0 +: BW];
                end
                `EMM_OFS_LOADA: lda_nxt = reg_wdata[RW-1:0];
                `EMM_OFS_LOADD: lda_nxt = RW'(lda_r + 1'b1);
                default: ;
            endcase
        end
        // Set wins over a same-cycle clear
        if (bad_rom) stat_nxt[`EMM_ST_ROMWR] = 1'b1;
        if (bad_grd) stat_nxt[`EMM_ST_GUARD] = 1'b1;
        if (reg_rd) begin
            case (reg_addr)
                `EMM_OFS_CTRL: rdata_nxt = ctrl_r;
                `EMM_OFS_STATUS: rdata_nxt = {30'h0, stat_r};
                `EMM_OFS_SEL: rdata_nxt = 32'(sel_r);
                `EMM_OFS_ENTRY: rdata_nxt = ent_word(int'(sel_r));
                `EMM_OFS_LOADA: rdata_nxt = 32'(lda_r);
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Output next state
    // ----------------------------------------
    logic [AW-1:0] taddr_nxt;
    logic tbuf_nxt, ebuf_nxt, wrok_nxt, ill_nxt, brk_nxt;
    logic [1:0] rcat_nxt;

    always_comb begin
        taddr_nxt = cpu_addr;
        tbuf_nxt = cpu_req && !emul && !is_guard;
        ebuf_nxt = cpu_req && emul;
        rcat_nxt = attr;
        wrok_nxt = is_ram;
        ill_nxt = bad_rom || bad_grd;
        brk_nxt = (bad_rom && ctrl_r[`EMM_CTRL_BRK_ROM])
                  || (bad_grd && ctrl_r[`EMM_CTRL_NRT]);
    end

    logic [AW-1:0] taddr_r;
    logic tbuf_r, ebuf_r, wrok_r, ill_r, brk_r;
    logic [1:0] rcat_r;

    // Register everything; control state reset to guarded default
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ent_valid_r <= '0;
            ent_emul_r <= '0;
            for (int i = 0; i < NENT; i++) begin
                ent_attr_r[i] <= 2'h2;
                ent_lo_r[i] <= '0;
                ent_hi_r[i] <= '0;
                ent_pg_r[i] <= '0;
            end
            ctrl_r <= `EMM_CTRL_RST;
            stat_r <= 2'h0;
            sel_r <= '0;
            lda_r <= '0;
            rdata_r <= 32'h0000_0000;
            taddr_r <= '0;
            tbuf_r <= 1'b0;
            ebuf_r <= 1'b0;
            rcat_r <= 2'h2;
            wrok_r <= 1'b0;
            ill_r <= 1'b0;
            brk_r <= 1'b0;
        end else begin
            ent_valid_r <= ent_valid_nxt;
            ent_emul_r <= ent_emul_nxt;
            ent_attr_r <= ent_attr_nxt;
            ent_lo_r <= ent_lo_nxt;
            ent_hi_r <= ent_hi_nxt;
            ent_pg_r <= ent_pg_nxt;
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            sel_r <= sel_nxt;
            lda_r <= lda_nxt;
            rdata_r <= rdata_nxt;
            taddr_r <= taddr_nxt;
            tbuf_r <= tbuf_nxt;
            ebuf_r <= ebuf_nxt;
            rcat_r <= rcat_nxt;
            wrok_r <= wrok_nxt;
            ill_r <= ill_nxt;
            brk_r <= brk_nxt;
        end
    end

    // Processor read data mirror the RAM register directly
    always_comb begin
        reg_rdata = rdata_r;
        cpu_rdata = mem_q;
        tgt_addr = taddr_r;
        tgt_buf_en = tbuf_r;
        emu_buf_en = ebuf_r;
        rc_attr = rcat_r;
        rc_wr_ok = wrok_r;
        illegal = ill_r;
        brk_req = brk_r;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_rom_wr;
        cpu_req && cpu_wr && is_rom;
    endsequence

    AST_ROM_WR_FLAG: assert property (@(posedge mclk) disable iff (rst)
        s_rom_wr |=> illegal && stat_r[0]) else $error("rom write not flagged");
    AST_ROM_NO_WRITE: assert property (@(posedge mclk) disable iff (rst)
        s_rom_wr |-> !ram_we) else $error("rom write reached ram");
    AST_ROM_BRK: assert property (@(posedge mclk) disable iff (rst)
        (s_rom_wr and ctrl_r[`EMM_CTRL_BRK_ROM]) |=> brk_req) else $error("no break on rom write");
    AST_GUARD_FLAG: assert property (@(posedge mclk) disable iff (rst)
        cpu_req && is_guard |=> illegal && stat_r[1]) else $error("guard not flagged");
    AST_GUARD_BRK: assert property (@(posedge mclk) disable iff (rst)
        cpu_req && is_guard && ctrl_r[1] |=> brk_req) else $error("no guard break");
    AST_TGT_PASS: assert property (@(posedge mclk) disable iff (rst)
        cpu_req |=> tgt_addr == $past(cpu_addr)) else $error("target addr changed");
    AST_TGT_BUF: assert property (@(posedge mclk) disable iff (rst)
        tgt_buf_en |-> !emu_buf_en) else $error("both buffer sets on");
    AST_OFFSET: assert property (@(posedge mclk) disable iff (rst)
        mem_we && !load_we |-> mem_a[PGW-1:0] == cpu_addr[PGW-1:0]) else $error("offset lost");
    AST_LOAD_ROM: assert property (@(posedge mclk) disable iff (rst)
        load_we |-> mem_we && mem_a == lda_r) else $error("control load blocked");
    AST_DEFAULT: assert property (@(posedge mclk) disable iff (rst)
        cpu_req && !hit |=> rc_attr == $past(ctrl_r[`EMM_CTRL_DEF_HI:`EMM_CTRL_DEF_LO]))
        else $error("default attr not used");

endmodule : emm_mapper

`default_nettype wire

// ---- test/emm_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Emulation processor in the probe
// ----------------------------------------
module emm_cpu_model (
    input wire logic mclk,
    output logic cpu_req,
    output logic cpu_wr,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_wdata
);
    // Idle bus at time zero
    initial begin
        cpu_req = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = 16'hffff;
        cpu_wdata = 8'h00;
    end

    // One access held until its taking edge; lines scrambled afterwards
    // so a stale address never passes for a live one
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_req <= 1'b1;
        cpu_wr <= wr;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_req <= 1'b0;
        cpu_wr <= 1'b0;
        cpu_addr <= ~a;
        cpu_wdata <= ~d;
    endtask : access
endmodule : emm_cpu_model

`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module tb;
    logic mclk;
    logic rst;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic cpu_req;
    logic cpu_wr;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_wdata;
    logic [7:0] cpu_rdata;
    logic [15:0] tgt_addr;
    logic tgt_buf_en;
    logic emu_buf_en;
    logic [1:0] rc_attr;
    logic rc_wr_ok;
    logic illegal;
    logic brk_req;
    logic [6:0] map_o;
    logic [31:0] rd_v;
    int num_errors;
    int n_compared;

    // Map outputs packed: tgt, emu, attr, wr_ok, illegal, brk
    assign map_o = {tgt_buf_en, emu_buf_en, rc_attr, rc_wr_ok, illegal, brk_req};

    emm_mapper emm_mapper_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .tgt_addr(tgt_addr), .tgt_buf_en(tgt_buf_en),
        .emu_buf_en(emu_buf_en), .rc_attr(rc_attr), .rc_wr_ok(rc_wr_ok),
        .illegal(illegal), .brk_req(brk_req));

    emm_cpu_model emm_cpu_model_i (.mclk(mclk), .cpu_req(cpu_req), .cpu_wr(cpu_wr),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));

    // ----------------------------------------
    // Clock, watchdog, closing
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Whole run is under a hundred cycles; generous margin
    initial begin
        #(4000 * 25);
        num_errors++;
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // Map outputs are sampled in the cycle after the request
    task automatic cpu_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        emm_cpu_model_i.access(wr, a, d);
        #1;
    endtask : cpu_acc

    function automatic logic [31:0] ent(input logic emul, input logic [1:0] attr,
        input logic [1:0] base, input logic [7:0] lo, input logic [7:0] hi);
        ent = {1'b1, emul, attr, 2'h0, base, 4'h0, hi, 4'h0, lo};
    endfunction : ent

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_after_reset();
        reg_read(4'h0, rd_v);
        `CHK("ctrl reset", 32'h0000_0008, rd_v);
        reg_read(4'hf, rd_v);
        `CHK("unmapped index", 32'h0000_0000, rd_v);
        reg_read(4'h1, rd_v);
        `CHK("status reset", 32'h0000_0000, rd_v);
    endtask : t_after_reset

    // ROM block on page 1 loaded by the control board
    task automatic t_setup();
        reg_write(4'h0, 32'h0000_0008);
        reg_write(4'h2, 32'h0000_0000);
        reg_write(4'h3, ent(1'b1, 2'h1, 2'h1, 8'h00, 8'h00));
        reg_write(4'h2, 32'h0000_0001);
        reg_write(4'h3, ent(1'b0, 2'h0, 2'h0, 8'h01, 8'h01));
        reg_write(4'h2, 32'h0000_0002);
        reg_write(4'h3, ent(1'b1, 2'h0, 2'h2, 8'h10, 8'h11));
        reg_write(4'h2, 32'h0000_0003);
        reg_write(4'h3, ent(1'b0, 2'h1, 2'h0, 8'h20, 8'h23));
        reg_write(4'h4, 32'h0000_0105);
        reg_write(4'h5, 32'h0000_00a5);
        reg_read(4'h4, rd_v);
        `CHK("load address step", 32'h0000_0106, rd_v);
        reg_read(4'h3, rd_v);
        `CHK("entry readback", ent(1'b0, 2'h1, 2'h0, 8'h20, 8'h23), rd_v);
    endtask : t_setup

    task automatic t_rom();
        cpu_acc(1'b0, 16'h0005, 8'h00);
        `CHK("rom read map", 7'h28, map_o);
        `CHK("rom read data", 8'ha5, cpu_rdata);
        cpu_acc(1'b1, 16'h0005, 8'h3c);
        `CHK("rom write map", 7'h2a, map_o);
        cpu_acc(1'b0, 16'h0005, 8'h00);
        `CHK("rom kept", 8'ha5, cpu_rdata);
        reg_write(4'h0, 32'h0000_0009);
        cpu_acc(1'b1, 16'h0005, 8'h77);
        `CHK("rom write brk", 7'h2b, map_o);
        cpu_acc(1'b0, 16'h0005, 8'h00);
        `CHK("rom kept brk", 8'ha5, cpu_rdata);
        reg_write(4'h0, 32'h0000_0008);
    endtask : t_rom

    task automatic t_target();
        cpu_acc(1'b1, 16'h0123, 8'h44);
        `CHK("target ram map", 7'h44, map_o);
        `CHK("target ram addr", 16'h0123, tgt_addr);
        cpu_acc(1'b0, 16'h23ff, 8'h00);
        `CHK("target rom map", 7'h48, map_o);
        `CHK("target rom addr", 16'h23ff, tgt_addr);
    endtask : t_target

    // Two pages of one block land on separate emulation pages
    task automatic t_ram();
        cpu_acc(1'b1, 16'h1034, 8'h11);
        `CHK("ram write map", 7'h24, map_o);
        cpu_acc(1'b1, 16'h1134, 8'h5a);
        cpu_acc(1'b0, 16'h1034, 8'h00);
        `CHK("ram page a", 8'h11, cpu_rdata);
        cpu_acc(1'b0, 16'h1134, 8'h00);
        `CHK("ram page b", 8'h5a, cpu_rdata);
        cpu_acc(1'b0, 16'h1200, 8'h00);
        `CHK("past block end", 7'h12, map_o);
    endtask : t_ram

    task automatic t_guard();
        cpu_acc(1'b0, 16'h5000, 8'h00);
        `CHK("guard read", 7'h12, map_o);
        reg_write(4'h0, 32'h0000_000a);
        cpu_acc(1'b1, 16'h5000, 8'h99);
        `CHK("guard nrt brk", 7'h13, map_o);
        reg_write(4'h0, 32'h0000_0004);
        cpu_acc(1'b0, 16'h5000, 8'h00);
        `CHK("target rom default", 7'h48, map_o);
    endtask : t_guard

    task automatic t_status();
        reg_read(4'h1, rd_v);
        `CHK("status seen", 32'h0000_0003, rd_v);
        reg_write(4'h1, 32'h0000_0003);
        reg_read(4'h1, rd_v);
        `CHK("status cleared", 32'h0000_0000, rd_v);
    endtask : t_status

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        num_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        `CHK("map in reset", 7'h10, map_o);
        @(posedge mclk);
        rst <= 1'b0;
        t_after_reset();
        t_setup();
        t_rom();
        t_target();
        t_ram();
        t_guard();
        t_status();
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
